// ==== pgm_port1.sv ====
`include "pgm_map.svh"
`default_nettype none
module pgm_port1 #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    // avalon-mm slave
    input  wire logic [`PGM_ADDR_W-1:0] avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [3:0]             avs_byteenable,
    input  wire logic [31:0]            avs_writedata,
    output var  logic [31:0]            avs_readdata,
    output var  logic                   avs_waitrequest,
    output var  logic                   irq,
    // port pins
    input  wire logic [W-1:0]           pin_in,
    output var  logic [W-1:0]           pin_out,
    output var  logic [W-1:0]           pin_oe_n,
    output var  logic [W-1:0]           pin_pullup,
    // alternate outputs from peripherals
    input  wire logic                   pwm_out_src,
    input  wire logic                   timer_f_high_out,
    input  wire logic                   timer_f_low_out,
    input  wire logic                   clock_timer_out,
    // alternate inputs to peripherals
    output var  logic                   ext_int3_in,
    output var  logic                   ext_int2_in,
    output var  logic                   ext_int1_in,
    output var  logic                   timer_f_event_in,
    output var  logic                   timer_y_clock_in,
    output var  logic                   timer_g_capture_in,
    output var  logic [2:0]             ext_int_edge
);
    typedef struct packed {
        pgm_pkg::pgm_bus_state_t bus;
        logic [W-1:0]            pin_function_select;
        logic [W-1:0]            pullup_enable;
        logic [W-1:0]            port_output_data;
        logic [W-1:0]            port_direction;
        logic [2:0]              edge_rising;
        logic [2:0]              irq_status;
        logic [2:0]              irq_mask;
        logic [31:0]             readdata;
        logic                    waitreq;
        logic                    irq;
        logic [W-1:0]            pin_out;
        logic [W-1:0]            pin_oe_n;
        logic [W-1:0]            pin_pullup;
        logic [5:0]              alt_in;
    } pgm_state_t;

    pgm_state_t   st;
    pgm_state_t   next_st;
    logic [W-1:0] pin_sync;
    logic [W-1:0] drive_en;
    logic [W-1:0] alt_out;
    logic [W-1:0] port_read;

    pgm_edge_if #(.N(`PGM_INT_N)) edges ();

    // ************************************************************
    // pin input synchroniser
    // ************************************************************
    pgm_sync #(.W(W)) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    // ************************************************************
    // interrupt edge sensing
    // ************************************************************
    assign edges.level      = {pin_sync[`PGM_BIT_INT3],
                               pin_sync[`PGM_BIT_INT2],
                               pin_sync[`PGM_BIT_INT1]};
    assign edges.rising_sel = st.edge_rising;
    assign edges.armed      = {st.pin_function_select[`PGM_BIT_INT3],
                               st.pin_function_select[`PGM_BIT_INT2],
                               st.pin_function_select[`PGM_BIT_INT1]};

    pgm_edge_det #(.N(`PGM_INT_N)) u_edge (
        .core_clk (core_clk),
        .rst      (rst),
        .edges    (edges)
    );

    // byte lane merge; registers are 8 bits in lane 0
    function automatic logic [W-1:0] lane0(input logic [W-1:0] old_v,
                                           input logic [3:0]   be,
                                           input logic [31:0]  wd);
        lane0 = be[0] ? wd[W-1:0] : old_v;
    endfunction

    // ************************************************************
    // pin function mux
    // ************************************************************
    always_comb begin
        alt_out = '0;
        alt_out[`PGM_BIT_PWM] = pwm_out_src;
        alt_out[`PGM_BIT_TFH] = timer_f_high_out;
        alt_out[`PGM_BIT_TFL] = timer_f_low_out;
        alt_out[`PGM_BIT_CTO] = clock_timer_out;
    end

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_pin
            // alternate inputs (7,6,5,3) never drive; alternate outputs do
            assign drive_en[g] = st.pin_function_select[g]
                ? (g == `PGM_BIT_PWM || g == `PGM_BIT_TFH ||
                   g == `PGM_BIT_TFL || g == `PGM_BIT_CTO)
                : st.port_direction[g];
            assign port_read[g] = st.port_direction[g]
                ? st.port_output_data[g]
                : pin_sync[g];
        end
    endgenerate

    // ************************************************************
    // register file and bus
    // ************************************************************
    always_comb begin
        next_st = st;
        for (int i = 0; i < W; i++) begin
            next_st.pin_out[i] = st.pin_function_select[i]
                ? alt_out[i] : st.port_output_data[i];
        end
        next_st.pin_oe_n   = ~drive_en;
        // pull-up only on pins not being driven
        next_st.pin_pullup = st.pullup_enable & ~drive_en;
        next_st.alt_in[5] = st.pin_function_select[`PGM_BIT_INT3] &
                            pin_sync[`PGM_BIT_INT3];
        next_st.alt_in[4] = st.pin_function_select[`PGM_BIT_INT2] &
                            pin_sync[`PGM_BIT_INT2];
        next_st.alt_in[3] = st.pin_function_select[`PGM_BIT_INT1] &
                            pin_sync[`PGM_BIT_INT1];
        next_st.alt_in[2] = st.pin_function_select[`PGM_BIT_TMG] &
                            pin_sync[`PGM_BIT_TMG];
        next_st.alt_in[1:0] = '0;

        // sticky status: a new event wins over a clear in the same cycle
        next_st.irq_status = st.irq_status | edges.event_seen;
        next_st.waitreq    = 1'b1;

        unique case (st.bus)
            pgm_pkg::PGM_IDLE: begin
                if (avs_write) begin
                    // the write lands at the edge that sees waitrequest low
                    next_st.bus     = pgm_pkg::PGM_ANSWER;
                    next_st.waitreq = 1'b0;
                end else if (avs_read) begin
                    next_st.bus     = pgm_pkg::PGM_ANSWER;
                    next_st.waitreq = 1'b0;
                    unique case (avs_address)
                        `PGM_OFS_FUNC_SEL:
                            next_st.readdata = {24'h00_0000,
                                                st.pin_function_select};
                        `PGM_OFS_PULLUP:
                            next_st.readdata = {24'h00_0000,
                                                st.pullup_enable};
                        `PGM_OFS_OUT_DATA:
                            next_st.readdata = {24'h00_0000, port_read};
                        `PGM_OFS_DIRECTION:
                            next_st.readdata = {24'h00_0000,
                                                `PGM_DIR_READ};
                        `PGM_OFS_EDGE_SEL:
                            next_st.readdata = {29'h0000_0000,
                                                st.edge_rising};
                        `PGM_OFS_IRQ_STATUS:
                            next_st.readdata = {29'h0000_0000,
                                                st.irq_status};
                        `PGM_OFS_IRQ_MASK:
                            next_st.readdata = {29'h0000_0000,
                                                st.irq_mask};
                        default: next_st.readdata = `PGM_UNMAPPED_READ;
                    endcase
                end
            end
            pgm_pkg::PGM_ANSWER: begin
                // one idle cycle lets the master drop its request
                next_st.bus = pgm_pkg::PGM_IDLE;
                // master still holds address and data at this edge
                if (avs_write) begin
                    unique case (avs_address)
                        `PGM_OFS_FUNC_SEL: next_st.pin_function_select =
                            lane0(st.pin_function_select, avs_byteenable,
                                  avs_writedata);
                        `PGM_OFS_PULLUP: next_st.pullup_enable =
                            lane0(st.pullup_enable, avs_byteenable,
                                  avs_writedata);
                        `PGM_OFS_OUT_DATA: next_st.port_output_data =
                            lane0(st.port_output_data, avs_byteenable,
                                  avs_writedata);
                        `PGM_OFS_DIRECTION: next_st.port_direction =
                            lane0(st.port_direction, avs_byteenable,
                                  avs_writedata);
                        `PGM_OFS_EDGE_SEL: if (avs_byteenable[0]) begin
                            next_st.edge_rising = avs_writedata[2:0];
                        end
                        `PGM_OFS_IRQ_STATUS: if (avs_byteenable[0]) begin
                            next_st.irq_status = (st.irq_status &
                                ~avs_writedata[2:0]) | edges.event_seen;
                        end
                        `PGM_OFS_IRQ_MASK: if (avs_byteenable[0]) begin
                            next_st.irq_mask = avs_writedata[2:0];
                        end
                        default: begin
                        end
                    endcase
                end
            end
            default: next_st.bus = pgm_pkg::PGM_IDLE;
        endcase
        next_st.irq = |(next_st.irq_status & st.irq_mask);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st          <= '0;
            st.waitreq  <= 1'b1;
            st.pin_oe_n <= '1;
            st.bus      <= pgm_pkg::PGM_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // timer Y clock shares pin 6; software keeps int2 disabled then
    assign avs_readdata       = st.readdata;
    assign avs_waitrequest    = st.waitreq;
    assign irq                = st.irq;
    assign pin_out            = st.pin_out;
    assign pin_oe_n           = st.pin_oe_n;
    assign pin_pullup         = st.pin_pullup;
    assign ext_int3_in        = st.alt_in[5];
    assign timer_f_event_in   = st.alt_in[5];
    assign ext_int2_in        = st.alt_in[4];
    assign timer_y_clock_in   = st.alt_in[4];
    assign ext_int1_in        = st.alt_in[3];
    assign timer_g_capture_in = st.alt_in[2];
    assign ext_int_edge       = st.edge_rising;
endmodule
`default_nettype wire

// ==== pgm_map.svh ====
// Overview of operation
// - output pins read back data register value
// - input pins read sampled pin level
// - direction 1 drives pin, 0 makes input
// - direction and data only in general mode
// - direction register reads as all ones
// - pull-up follows enable on input pins
// - reset clears all seven registers
// - select bit 7 routes int3, timer F
// - select bit 6 routes int2, timer Y
// - select bit 5 routes external interrupt 1
// - select bit 4 drives pulse-width output
// - select bit 3 routes timer G capture
// - select bit 2 drives timer F high
// - select bit 1 drives timer F low
// - select bit 0 drives clock timer
// - interrupt pins sense chosen edge
`ifndef PGM_MAP_SVH
`define PGM_MAP_SVH
`define PGM_ADDR_W          16
`define PGM_OFS_FUNC_SEL    16'hFF98
`define PGM_OFS_PULLUP      16'hFF9C
`define PGM_OFS_OUT_DATA    16'hFFD4
`define PGM_OFS_DIRECTION   16'hFFE4
`define PGM_OFS_EDGE_SEL    16'hFFF0
`define PGM_OFS_IRQ_STATUS  16'hFFF4
`define PGM_OFS_IRQ_MASK    16'hFFF8
`define PGM_RST_REG         8'h00
`define PGM_DIR_READ        8'hFF
`define PGM_UNMAPPED_READ   32'h0000_0000
`define PGM_BIT_INT3        7
`define PGM_BIT_INT2        6
`define PGM_BIT_INT1        5
`define PGM_BIT_PWM         4
`define PGM_BIT_TMG         3
`define PGM_BIT_TFH         2
`define PGM_BIT_TFL         1
`define PGM_BIT_CTO         0
`define PGM_INT_N           3
`endif

// ==== pgm_pkg.sv ====
`default_nettype none
package pgm_pkg;
    typedef enum logic [1:0] {
        PGM_IDLE,
        PGM_ANSWER
    } pgm_bus_state_t;
endpackage
`default_nettype wire

// ==== pgm_edge_if.sv ====
`default_nettype none
interface pgm_edge_if #(parameter int N = 3);
    logic [N-1:0] level;
    logic [N-1:0] rising_sel;
    logic [N-1:0] armed;
    logic [N-1:0] event_seen;
    modport ctrl (output level, output rising_sel, output armed,
                  input event_seen);
    modport det  (input level, input rising_sel, input armed,
                  output event_seen);
endinterface
`default_nettype wire

// ==== pgm_sync.sv ====
`default_nettype none
module pgm_sync #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst,
    // data
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } pgm_sync_state_t;

    pgm_sync_state_t st;
    pgm_sync_state_t next_st;

    always_comb begin
        next_st        = st;
        next_st.stage1 = async_in;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.stage2;
endmodule
`default_nettype wire

// ==== pgm_edge_det.sv ====
`default_nettype none
module pgm_edge_det #(
    parameter int N = 3
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // edge sensing
    pgm_edge_if.det   edges
);
    typedef struct packed {
        logic [N-1:0] prev;
        logic [N-1:0] event_seen;
    } pgm_edge_state_t;

    pgm_edge_state_t st;
    pgm_edge_state_t next_st;

    always_comb begin
        next_st      = st;
        next_st.prev = edges.level;
        for (int i = 0; i < N; i++) begin
            // disarmed channels keep tracking so enabling never fakes an edge
            next_st.event_seen[i] = edges.armed[i] &&
                (edges.rising_sel[i] ? (edges.level[i] && !st.prev[i])
                                     : (!edges.level[i] && st.prev[i]));
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign edges.event_seen = st.event_seen;
endmodule
`default_nettype wire

// ==== pgm_port1_props.sv ====
`include "pgm_map.svh"
`default_nettype none
module pgm_port1_props #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic                   core_clk,
    input wire logic                   rst,
    // register bus
    input wire logic [`PGM_ADDR_W-1:0] avs_address,
    input wire logic                   avs_read,
    input wire logic                   avs_write,
    input wire logic                   avs_waitrequest,
    input wire logic [31:0]            avs_readdata,
    input wire logic                   irq,
    // pins and routed inputs
    input wire logic [W-1:0]           pin_oe_n,
    input wire logic [W-1:0]           pin_pullup,
    input wire logic                   ext_int3_in,
    input wire logic                   timer_f_event_in,
    input wire logic                   ext_int2_in,
    input wire logic                   timer_y_clock_in,
    input wire logic                   ext_int1_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // ********
    // properties
    // ********
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_bus_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered");
    chk_bus_single: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("answer held too long");
    chk_dir_ones: assert property (avs_read && avs_waitrequest
        && avs_address == `PGM_OFS_DIRECTION |=> avs_readdata == 32'hFF)
        else $error("direction read not all ones");
    chk_pull_input: assert property (
        (pin_pullup & ~pin_oe_n) == '0)
        else $error("pull-up on a driven pin");
    chk_reset_state: assert property (
        $past(rst) |-> pin_pullup == '0 && pin_oe_n == {W{1'b1}})
        else $error("bad state after reset");
    chk_int3_pair: assert property (
        ext_int3_in == timer_f_event_in)
        else $error("pin 7 routes differ");
    chk_int2_pair: assert property (
        ext_int2_in == timer_y_clock_in)
        else $error("pin 6 routes differ");
    chk_alt_undriven: assert property (
        ext_int1_in |-> pin_oe_n[5])
        else $error("alternate input pin driven");

    cover property (!avs_waitrequest && $past(avs_read));
    cover property ($rose(irq));
    cover property ($rose(ext_int2_in));
endmodule

bind pgm_port1 pgm_port1_props #(.W(W)) u_props (.core_clk, .rst,
    .avs_address, .avs_read, .avs_write, .avs_waitrequest, .avs_readdata,
    .irq, .pin_oe_n, .pin_pullup, .ext_int3_in, .timer_f_event_in,
    .ext_int2_in, .timer_y_clock_in, .ext_int1_in);
`default_nettype wire

// ==== pgm_board.sv ====
`default_nettype none
module pgm_board #(
    parameter int W = 8
) (
    // clock
    input  wire logic         core_clk,
    // device side
    input  wire logic [W-1:0] pin_out,
    input  wire logic [W-1:0] pin_oe_n,
    input  wire logic [W-1:0] pin_pullup,
    output var  logic [W-1:0] pin_in,
    // board stimulus
    input  wire logic [W-1:0] ext_lvl,
    input  wire logic [W-1:0] ext_en
);
    timeunit 1ns;
    timeprecision 1ps;

    // ********
    // pin levels
    // ********
    // a floating pin wanders so a stale value never passes for a read
    logic [W-1:0] drift = '0;

    always @(posedge core_clk) begin
        drift <= ~drift;
    end

    // a strong board driver overpowers the port, as on a shorted net
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (ext_en[i]) begin
                pin_in[i] = ext_lvl[i];
            end else if (!pin_oe_n[i]) begin
                pin_in[i] = pin_out[i];
            end else if (pin_pullup[i]) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = drift[i];
            end
        end
    end
endmodule
`default_nettype wire

// ==== test_port1_gpio_pin_mux.sv ====
`include "pgm_map.svh"
`default_nettype none
module test_port1_gpio_pin_mux;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, rst, avs_read, avs_write, avs_waitrequest, irq;
    logic        pwm_out_src, timer_f_high_out, timer_f_low_out;
    logic        clock_timer_out, ext_int3_in, ext_int2_in, ext_int1_in;
    logic        timer_f_event_in, timer_y_clock_in, timer_g_capture_in;
    logic [2:0]  ext_int_edge;
    logic [15:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [7:0]  pin_in, pin_out, pin_oe_n, pin_pullup, ext_lvl, ext_en;
    int          fail_count = 0;
    int          tests_run = 0;

    pgm_port1 dut_u (.core_clk, .rst, .avs_address, .avs_read, .avs_write,
        .avs_byteenable(4'hF), .avs_writedata, .avs_readdata,
        .avs_waitrequest, .irq, .pin_in, .pin_out, .pin_oe_n, .pin_pullup,
        .pwm_out_src, .timer_f_high_out, .timer_f_low_out, .clock_timer_out,
        .ext_int3_in, .ext_int2_in, .ext_int1_in, .timer_f_event_in,
        .timer_y_clock_in, .timer_g_capture_in, .ext_int_edge);
    pgm_board u_board (.core_clk, .pin_out, .pin_oe_n, .pin_pullup,
        .pin_in, .ext_lvl, .ext_en);

    // ********
    // helpers
    // ********
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    // waits on waitrequest itself; only the watchdog ends a hang
    task automatic rd(input logic [15:0] a, output logic [31:0] q,
                      input logic w = 1'b0, input logic [7:0] d = 8'h00);
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= {24'h0, d};
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [31:0] q;
        rd(a, q, 1'b1, d);
    endtask

    task automatic pins(input logic [7:0] lvl, input logic [7:0] en);
        @(posedge core_clk);
        ext_lvl <= lvl;
        ext_en <= en;
        repeat (8) @(posedge core_clk);
    endtask

    // ********
    // scenarios
    // ********
    task automatic t_reset;
        logic [31:0] q;
        pins(8'hA5, 8'hFF);
        chk(32'(pin_oe_n), 32'hFF);
        chk(32'(pin_pullup), 32'h00);
        chk(32'(pin_out), 32'h00);
        rd(`PGM_OFS_FUNC_SEL, q); chk(q, 32'h00);
        rd(`PGM_OFS_PULLUP, q); chk(q, 32'h00);
        rd(`PGM_OFS_OUT_DATA, q); chk(q, 32'hA5);
        rd(`PGM_OFS_DIRECTION, q); chk(q, 32'hFF);
    endtask

    task automatic t_mixed;
        logic [31:0] q;
        wr(`PGM_OFS_DIRECTION, 8'hF0);
        wr(`PGM_OFS_OUT_DATA, 8'hAA);
        pins(8'h55, 8'hFF);
        rd(`PGM_OFS_OUT_DATA, q); chk(q, 32'hA5);
        rd(`PGM_OFS_DIRECTION, q); chk(q, 32'hFF);
        chk(32'(pin_oe_n), 32'h0F);
        chk(32'(pin_out & 8'hF0), 32'hA0);
    endtask

    task automatic t_pullup;
        logic [31:0] q;
        wr(`PGM_OFS_DIRECTION, 8'h0F);
        wr(`PGM_OFS_PULLUP, 8'hFF);
        pins(8'h00, 8'h00);
        chk(32'(pin_pullup), 32'hF0);
        rd(`PGM_OFS_OUT_DATA, q); chk(q, 32'hFA);
    endtask

    task automatic t_alt_out;
        wr(`PGM_OFS_DIRECTION, 8'h00);
        wr(`PGM_OFS_FUNC_SEL, 8'h17);
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            {pwm_out_src, timer_f_high_out} <= k ? 2'b10 : 2'b01;
            {timer_f_low_out, clock_timer_out} <= k ? 2'b11 : 2'b00;
            repeat (4) @(posedge core_clk);
            chk(32'(pin_out & 8'h17), k ? 32'h13 : 32'h04);
            chk(32'(pin_oe_n & 8'h17), 32'h00);
        end
    endtask

    task automatic t_alt_in;
        wr(`PGM_OFS_DIRECTION, 8'hFF);
        wr(`PGM_OFS_IRQ_MASK, 8'h05);
        wr(`PGM_OFS_FUNC_SEL, 8'hE8);
        pins(8'hE8, 8'hFF);
        chk(32'(pin_oe_n & 8'hE8), 32'hE8);
        chk(32'({ext_int3_in, timer_f_event_in, ext_int2_in, timer_y_clock_in,
            ext_int1_in, timer_g_capture_in}), 32'h3F);
        wr(`PGM_OFS_FUNC_SEL, 8'h00);
        pins(8'hE8, 8'hFF);
        chk(32'({ext_int3_in, ext_int2_in, ext_int1_in, timer_g_capture_in}),
            32'h0);
    endtask

    task automatic t_irq;
        logic [31:0] q;
        wr(`PGM_OFS_EDGE_SEL, 8'h07);
        pins(8'h00, 8'hFF);
        wr(`PGM_OFS_FUNC_SEL, 8'hE0);
        pins(8'h00, 8'hFF);
        wr(`PGM_OFS_IRQ_STATUS, 8'h07);
        wr(`PGM_OFS_IRQ_MASK, 8'h01);
        chk(32'(ext_int_edge), 32'h7);
        chk(32'(irq), 32'h0);
        pins(8'h20, 8'hFF);
        chk(32'(irq), 32'h1);
        rd(`PGM_OFS_IRQ_STATUS, q); chk(q, 32'h01);
        wr(`PGM_OFS_IRQ_STATUS, 8'h01);
        wr(`PGM_OFS_EDGE_SEL, 8'h00);
        chk(32'(irq), 32'h0);
        pins(8'h00, 8'hFF);
        rd(`PGM_OFS_IRQ_STATUS, q); chk(q, 32'h01);
        wr(`PGM_OFS_IRQ_MASK, 8'h00);
        repeat (3) @(posedge core_clk);
        chk(32'(irq), 32'h0);
    endtask

    // ********
    // run control
    // ********
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        #100us;
        fail_count++;
        report_and_stop;
    end

    initial begin
        rst = 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        {pwm_out_src, timer_f_high_out, timer_f_low_out} = 3'b000;
        clock_timer_out = 1'b0;
        ext_lvl = 8'h00;
        ext_en = 8'h00;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        t_reset;
        t_mixed;
        t_pullup;
        t_alt_out;
        t_alt_in;
        t_irq;
        report_and_stop;
    end
endmodule
`default_nettype wire
